// ===== src/srs_defines.svh
// Constants for the speed reference selector and deceleration mode block.
// Functional notes
// (RL1) Preset selector value 9 enables a timer that steps through presets.
// (RL2) Scan dwell time comes from the scan interval input.
// (RL3) Jog forward accepted only in ready, inhibit or trip state.
// (RL4) Eight stored presets; selecting preset n delivers the n-th value.
// (RL5) Keypad source: keypad keys drive sequencer, reference is keypad value.
// (RL6) Keypad source: sequencing bits ignored and jog blocked.
// (RL7) Precision source: reference built from coarse and fine values.
// (RL8) Analog modes: selector 2 to 8 picks that preset, terminals inert.
// (RL9) Preset mode: selector 1 to 8 picks that preset regardless of terminals.
// (RL10) Deceleration mode never changes the acceleration ramp.
// (RL11) In deceleration, no speed drop for 10 s forces reference to zero.
// (RL12) Stall forcing applies only in deceleration state, not zero reference.
// (RL13) Fast mode: speed falls at programmed deceleration rate.
// (RL14) Standard mode: bus regulator engages at configured bus voltage level.
// (RL15) Standard mode: regulator releases once deceleration reaches programmed rate.
// (RL16) Regulator output is a current demand using two current loop gains.
// (RL17) Selector 0 in preset modes: terminals form bits, value plus one.
// (RL18) Without autosetup disable, source change retargets terminals after reset.
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH
`define SRS_CLK_HZ        25000000
`define SRS_STALL_SEC     10
`define SRS_STALL_CYCLES  (`SRS_STALL_SEC * `SRS_CLK_HZ)
`define SRS_SCAN_UNIT_MS  1
`define SRS_SCAN_UNIT_CYC ((`SRS_CLK_HZ / 1000) * `SRS_SCAN_UNIT_MS)
`define SRS_SCAN_SEL      4'h9
`define SRS_DECEL_FAST    2'h0
`define SRS_DECEL_STD     2'h1
`endif

// ===== src/srs_pkg.sv
// Types shared by the speed reference selector block.
package srs_pkg;
	typedef enum logic [2:0] {
		SRS_SRC_ANALOG_PAIR = 3'h0,
		SRS_SRC_A1_PRESETS  = 3'h1,
		SRS_SRC_A2_PRESETS  = 3'h2,
		SRS_SRC_PRESETS     = 3'h3,
		SRS_SRC_KEYPAD      = 3'h4,
		SRS_SRC_PRECISION   = 3'h5
	} srs_source_t;

	typedef enum logic [1:0] {
		SRS_DRV_READY   = 2'h0,
		SRS_DRV_INHIBIT = 2'h1,
		SRS_DRV_TRIP    = 2'h2,
		SRS_DRV_RUN     = 2'h3
	} srs_drive_t;

	// Regulator state: Gray-coded along idle -> regulate -> release.
	typedef enum logic [1:0] {
		SRS_REG_IDLE    = 2'b00,
		SRS_REG_ACTIVE  = 2'b01,
		SRS_REG_RELEASE = 2'b11
	} srs_reg_t;

	typedef struct packed {
		logic a_meta;
		logic a_sync;
		logic b_meta;
		logic b_sync;
	} srs_term_t;

	typedef struct packed {
		logic [15:0] analog1;
		logic [15:0] analog2;
		logic [15:0] keypad;
		logic [15:0] coarse;
		logic [15:0] fine;
	} srs_refs_t;
endpackage

// ===== src/srs_speed_ref.sv
// Speed reference source selection, preset scan, stall watchdog and decel regulator.
`timescale 1ns/10ps
`default_nettype none
`include "srs_defines.svh"
module srs_speed_ref
	import srs_pkg::*;
#(
	parameter int          NUM_PRESETS  = 8,
	parameter int          REF_W        = 16,
	parameter int unsigned STALL_CYCLES = `SRS_STALL_CYCLES,
	parameter int unsigned SCAN_UNIT    = `SRS_SCAN_UNIT_CYC
) (
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire logic [2:0]              reference_source_select,
	input  wire logic [3:0]              preset_selector,
	input  wire logic [15:0]             preset_scan_interval,
	input  wire srs_refs_t               refs,
	input  wire logic [NUM_PRESETS*REF_W-1:0] preset_values,
	input  wire logic                    terminal_a,
	input  wire logic                    terminal_b,
	input  wire logic                    terminal_autosetup_disable,
	input  wire logic                    drive_reset,
	input  wire srs_drive_t              drive_state,
	input  wire logic [7:0]              sequencer_bits,
	input  wire logic [7:0]              keypad_keys,
	input  wire logic                    in_decel,
	input  wire logic [REF_W-1:0]        speed_abs,
	input  wire logic [1:0]              decel_mode_select,
	input  wire logic [REF_W-1:0]        bus_voltage,
	input  wire logic [REF_W-1:0]        bus_voltage_brake_level,
	input  wire logic [REF_W-1:0]        decel_actual,
	input  wire logic [REF_W-1:0]        decel_programmed,
	input  wire logic [7:0]              current_loop_prop_gain,
	input  wire logic [7:0]              current_loop_int_gain,
	output logic [REF_W-1:0]             active_reference,
	output logic [2:0]                   selected_source_indicator,
	output logic [3:0]                   selected_preset_indicator,
	output logic [7:0]                   sequencer_command,
	output logic                         jog_forward_accepted,
	output logic                         terminals_are_preset_bits,
	output logic                         stall_force_zero,
	output logic                         regulator_active,
	output logic [REF_W-1:0]             current_demand,
	output logic [REF_W-1:0]             decel_rate_limit
);

	// Elaboration refuses widths and counts that the selector and counters cannot serve.
	if (NUM_PRESETS != 8 || REF_W < 8 || REF_W > 16 || SCAN_UNIT < 1 || STALL_CYCLES < 2) begin : g_param_check
		$error("srs_speed_ref: unsupported parameters");
	end

	// Selects the stored preset with index 1..NUM_PRESETS.
	function automatic logic [REF_W-1:0] pick_preset(input logic [NUM_PRESETS*REF_W-1:0] v, input logic [3:0] n);
		logic [REF_W-1:0] r;
		r = '0;
		for (int i = 0; i < NUM_PRESETS; i++) begin
			if (n == 4'(i + 1))
				r = v[i*REF_W +: REF_W];
		end
		return r;
	endfunction

	// Presets-capable source modes share the terminal-as-select-bit behaviour.
	function automatic logic preset_capable(input logic [2:0] s);
		return (s == SRS_SRC_A1_PRESETS) || (s == SRS_SRC_A2_PRESETS) || (s == SRS_SRC_PRESETS);
	endfunction

	typedef struct packed {
		srs_term_t        term;
		logic [2:0]       term_source;
		logic [3:0]       scan_preset;
		logic [15:0]      scan_ms;
		logic [31:0]      scan_unit;
		logic [31:0]      stall_cnt;
		logic [REF_W-1:0] stall_speed;
		logic             stall;
		srs_reg_t         reg_state;
		logic [REF_W+8:0] integ;
		logic [REF_W-1:0] demand;
		logic [REF_W-1:0] reference;
		logic [2:0]       src_ind;
		logic [3:0]       pre_ind;
	} srs_state_t;

	srs_state_t state;
	srs_state_t next_state;

	logic [3:0]       sel_preset;
	logic [REF_W-1:0] error_v;

	always_comb begin
		next_state = state;
		error_v    = '0;
		// Both terminals are synchronised; only the second flop is read.
		next_state.term.a_meta = terminal_a;
		next_state.term.a_sync = state.term.a_meta;
		next_state.term.b_meta = terminal_b;
		next_state.term.b_sync = state.term.b_meta;

		// Terminal function follows the source only at a drive reset when autosetup is on.
		if (drive_reset && !terminal_autosetup_disable)
			next_state.term_source = reference_source_select; // [RL18]

		// Scan timer: dwell of preset_scan_interval milliseconds per preset.
		if (preset_selector == `SRS_SCAN_SEL) begin // [RL1]
			if (state.scan_unit >= SCAN_UNIT - 1) begin
				next_state.scan_unit = '0;
				if (state.scan_ms + 16'h0001 >= preset_scan_interval) begin // [RL2]
					next_state.scan_ms     = '0;
					next_state.scan_preset = (state.scan_preset >= 4'(NUM_PRESETS)) ? 4'h1 : state.scan_preset + 4'h1;
				end else begin
					next_state.scan_ms = state.scan_ms + 16'h0001;
				end
			end else begin
				next_state.scan_unit = state.scan_unit + 32'h1;
			end
		end else begin
			next_state.scan_unit   = '0;
			next_state.scan_ms     = '0;
			next_state.scan_preset = 4'h1;
		end

		// Effective preset number: scan value, direct selector or terminal bits.
		if (preset_selector == `SRS_SCAN_SEL)
			sel_preset = state.scan_preset;
		else if (preset_selector == 4'h0 && preset_capable(state.term_source))
			sel_preset = {2'b00, state.term.b_sync, state.term.a_sync} + 4'h1; // [RL17]
		else if (preset_selector == 4'h0)
			sel_preset = 4'h1;
		else
			sel_preset = (preset_selector > 4'(NUM_PRESETS)) ? 4'(NUM_PRESETS) : preset_selector;

		// Source selection.
		next_state.pre_ind = sel_preset;
		case (reference_source_select)
			SRS_SRC_ANALOG_PAIR, SRS_SRC_A1_PRESETS, SRS_SRC_A2_PRESETS: begin
				if (sel_preset >= 4'h2) begin
					next_state.reference = pick_preset(preset_values, sel_preset); // [RL8]
					next_state.src_ind   = (reference_source_select == SRS_SRC_A2_PRESETS) ? 3'h2 : 3'h1;
				end else if (reference_source_select == SRS_SRC_A2_PRESETS ||
						(reference_source_select == SRS_SRC_ANALOG_PAIR && state.term.a_sync)) begin
					next_state.reference = REF_W'(refs.analog2);
					next_state.src_ind   = 3'h2;
				end else begin
					next_state.reference = REF_W'(refs.analog1);
					next_state.src_ind   = 3'h1;
				end
				if (reference_source_select != SRS_SRC_ANALOG_PAIR)
					next_state.src_ind = {1'b0, reference_source_select[1:0]};
			end
			SRS_SRC_PRESETS: begin
				next_state.reference = pick_preset(preset_values, sel_preset); // [RL9] [RL4]
				next_state.src_ind   = 3'h3;
			end
			SRS_SRC_KEYPAD: begin
				next_state.reference = REF_W'(refs.keypad); // [RL5]
				next_state.src_ind   = 3'h4;
				next_state.pre_ind   = 4'h0;
			end
			SRS_SRC_PRECISION: begin
				next_state.reference = REF_W'(refs.coarse + refs.fine); // [RL7]
				next_state.src_ind   = 3'h5;
				next_state.pre_ind   = 4'h0;
			end
			default: begin
				next_state.reference = REF_W'(refs.analog1);
				next_state.src_ind   = 3'h1;
			end
		endcase

		// Stall watchdog counts only in the deceleration state.
		if (!in_decel) begin // [RL12]
			next_state.stall_cnt   = '0;
			next_state.stall       = 1'b0;
			next_state.stall_speed = speed_abs;
		end else if (speed_abs < state.stall_speed) begin
			next_state.stall_cnt   = '0;
			next_state.stall_speed = speed_abs;
		end else if (state.stall_cnt >= STALL_CYCLES - 1) begin
			next_state.stall = 1'b1; // [RL11]
		end else begin
			next_state.stall_cnt = state.stall_cnt + 32'h1;
		end
		if (state.stall)
			next_state.reference = '0; // [RL11]

		// Bus voltage regulator for standard ramp during deceleration.
		case (state.reg_state)
			SRS_REG_IDLE: begin
				if (in_decel && decel_mode_select == `SRS_DECEL_STD && bus_voltage >= bus_voltage_brake_level)
					next_state.reg_state = SRS_REG_ACTIVE; // [RL14]
			end
			SRS_REG_ACTIVE: begin
				if (!in_decel || decel_mode_select != `SRS_DECEL_STD)
					next_state.reg_state = SRS_REG_IDLE;
				else if (decel_actual >= decel_programmed)
					next_state.reg_state = SRS_REG_RELEASE; // [RL15]
			end
			SRS_REG_RELEASE: begin
				if (!in_decel || decel_mode_select != `SRS_DECEL_STD)
					next_state.reg_state = SRS_REG_IDLE;
			end
			default: next_state.reg_state = SRS_REG_IDLE;
		endcase

		// PI current demand from the bus overshoot; gains are the two loop gains.
		if (state.reg_state == SRS_REG_ACTIVE) begin
			error_v = (bus_voltage > bus_voltage_brake_level) ? bus_voltage - bus_voltage_brake_level : '0;
			// Widen before the product so the gain never wraps, and shift only the new term.
			next_state.integ  = state.integ + (((REF_W+9)'(error_v) * (REF_W+9)'(current_loop_int_gain)) >> 4); // [RL16]
			next_state.demand = REF_W'((((REF_W+9)'(error_v) * current_loop_prop_gain) >> 4) + state.integ); // [RL16]
		end else begin
			next_state.integ  = '0;
			next_state.demand = '0;
		end
	end

	// All state registered at once; reset gives known constants.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state             <= '0;
			state.term_source <= SRS_SRC_ANALOG_PAIR;
			state.scan_preset <= 4'h1;
			state.reg_state   <= SRS_REG_IDLE;
			state.src_ind     <= 3'h1;
			state.pre_ind     <= 4'h1;
		end else begin
			state <= next_state;
		end
	end

	// Keypad source takes the sequencer from the keys and blocks jog.
	assign sequencer_command    = (reference_source_select == SRS_SRC_KEYPAD) ? keypad_keys : sequencer_bits; // [RL5] [RL6]
	assign jog_forward_accepted = (reference_source_select != SRS_SRC_KEYPAD) && // [RL6]
		(drive_state != SRS_DRV_RUN) && state.term.b_sync &&
		(state.term_source == SRS_SRC_ANALOG_PAIR); // [RL3]
	assign terminals_are_preset_bits = preset_capable(state.term_source) && preset_selector == 4'h0;

	assign active_reference          = state.reference;
	assign selected_source_indicator = state.src_ind;
	assign selected_preset_indicator = state.pre_ind;
	assign stall_force_zero          = state.stall;
	assign regulator_active          = state.reg_state == SRS_REG_ACTIVE;
	assign current_demand            = state.demand;
	// Fast mode and released regulator both hold the programmed rate; accel is untouched.
	assign decel_rate_limit = decel_programmed; // [RL13] [RL10]

endmodule
`default_nettype wire

// ===== tb/srs_speed_ref_monitor.sv
// Assertion checker for the speed reference selector ports.
`timescale 1ns/10ps
`default_nettype none
module srs_speed_ref_monitor
	import srs_pkg::*;
(
	input wire logic         clk,
	input wire logic         reset,
	input wire logic [2:0]   reference_source_select,
	input wire logic [3:0]   preset_selector,
	input wire logic [127:0] preset_values,
	input wire srs_refs_t    refs,
	input wire srs_drive_t   drive_state,
	input wire logic         in_decel,
	input wire logic [1:0]   decel_mode_select,
	input wire logic [15:0]  bus_voltage,
	input wire logic [15:0]  bus_voltage_brake_level,
	input wire logic [15:0]  decel_actual,
	input wire logic [15:0]  decel_programmed,
	input wire logic [15:0]  active_reference,
	input wire logic [2:0]   selected_source_indicator,
	input wire logic         jog_forward_accepted,
	input wire logic         stall_force_zero,
	input wire logic         regulator_active,
	input wire logic [15:0]  decel_rate_limit
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////////
	// Reference checks exclude deceleration, since the stall override wins over any source.
	chk_jog_keypad: assert property (
		reference_source_select == 3'h4 |-> !jog_forward_accepted) else $error("jog taken on keypad");
	chk_jog_run: assert property (
		drive_state == SRS_DRV_RUN |-> !jog_forward_accepted) else $error("jog taken while running");
	chk_keypad_ref: assert property (
		reference_source_select == 3'h4 && !in_decel && !stall_force_zero
		|=> active_reference == $past(refs.keypad)) else $error("keypad reference wrong");
	chk_preset_pick: assert property (
		reference_source_select == 3'h3 && preset_selector inside {[1:8]} && !in_decel && !stall_force_zero
		|=> active_reference == $past(preset_values[{preset_selector, 4'h0} - 8'h10 +: 16]))
		else $error("preset pick wrong");
	chk_src_ind: assert property (
		reference_source_select inside {3'h3, 3'h4, 3'h5}
		|=> selected_source_indicator == $past(reference_source_select)) else $error("source indicator wrong");
	chk_rate_pass: assert property (
		decel_rate_limit == decel_programmed) else $error("decel rate altered");
	////////////////////////////////////////////////////////////////////////////////
	// The regulator is idle whenever a deceleration starts, so a rise is a clean start.
	chk_reg_engage: assert property (
		$rose(in_decel) && decel_mode_select == 2'h1 && bus_voltage >= bus_voltage_brake_level
		&& decel_actual < decel_programmed |=> regulator_active) else $error("regulator did not engage");
	chk_reg_release: assert property (
		regulator_active && in_decel && decel_actual >= decel_programmed |=> !regulator_active)
		else $error("regulator did not release");
	chk_stall_zero: assert property (
		stall_force_zero |=> active_reference == 16'h0000) else $error("stall did not zero reference");
	chk_stall_decel: assert property (
		!in_decel [*2] |-> !stall_force_zero) else $error("stall outside deceleration");
endmodule
`default_nettype wire

// ===== tb/srs_host_model.sv
// Parameter-setting host model: holds the stored references and presets.
`timescale 1ns/10ps
`default_nettype none
module srs_host_model
	import srs_pkg::*;
(
	output var srs_refs_t refs,
	output logic [127:0]  preset_values
);
	// Every value differs, so a wrong pick can never pass for a right one.
	always_comb begin
		refs = '{16'h0a01, 16'h0a02, 16'h0b00, 16'h0c00, 16'h0012};
		for (int n = 0; n < 8; n++) begin
			preset_values[n*16 +: 16] = 16'h0100 + 16'(n + 1);
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the speed reference selector.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import srs_pkg::*;
	logic         clk, reset, terminal_a, terminal_b, terminal_autosetup_disable, drive_reset, in_decel;
	logic         jog_forward_accepted, terminals_are_preset_bits, stall_force_zero, regulator_active;
	logic [1:0]   decel_mode_select;
	logic [2:0]   reference_source_select, selected_source_indicator;
	logic [3:0]   preset_selector, selected_preset_indicator, v;
	logic [7:0]   sequencer_bits, keypad_keys, sequencer_command, current_loop_prop_gain, current_loop_int_gain;
	logic [15:0]  preset_scan_interval, speed_abs, bus_voltage, bus_voltage_brake_level, decel_actual;
	logic [15:0]  decel_programmed, active_reference, current_demand, decel_rate_limit;
	logic [127:0] preset_values;
	srs_refs_t    refs;
	srs_drive_t   drive_state;
	int           failures, compares;
	int           dwell;
	// Short counts keep the stall and scan waits to a few dozen cycles.
	srs_speed_ref #(
		.STALL_CYCLES(50),
		.SCAN_UNIT   (2)
	) dut_u (
		.clk                        (clk),
		.reset                      (reset),
		.reference_source_select    (reference_source_select),
		.preset_selector            (preset_selector),
		.preset_scan_interval       (preset_scan_interval),
		.refs                       (refs),
		.preset_values              (preset_values),
		.terminal_a                 (terminal_a),
		.terminal_b                 (terminal_b),
		.terminal_autosetup_disable (terminal_autosetup_disable),
		.drive_reset                (drive_reset),
		.drive_state                (drive_state),
		.sequencer_bits             (sequencer_bits),
		.keypad_keys                (keypad_keys),
		.in_decel                   (in_decel),
		.speed_abs                  (speed_abs),
		.decel_mode_select          (decel_mode_select),
		.bus_voltage                (bus_voltage),
		.bus_voltage_brake_level    (bus_voltage_brake_level),
		.decel_actual               (decel_actual),
		.decel_programmed           (decel_programmed),
		.current_loop_prop_gain     (current_loop_prop_gain),
		.current_loop_int_gain      (current_loop_int_gain),
		.active_reference           (active_reference),
		.selected_source_indicator  (selected_source_indicator),
		.selected_preset_indicator  (selected_preset_indicator),
		.sequencer_command          (sequencer_command),
		.jog_forward_accepted       (jog_forward_accepted),
		.terminals_are_preset_bits  (terminals_are_preset_bits),
		.stall_force_zero           (stall_force_zero),
		.regulator_active           (regulator_active),
		.current_demand             (current_demand),
		.decel_rate_limit           (decel_rate_limit)
	);
	srs_host_model host_u (.refs(refs), .preset_values(preset_values));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Registered outputs need one edge, terminals three; four edges cover both.
	task automatic sel(input logic [2:0] s, input logic [3:0] p);
		@(posedge clk);
		{reference_source_select, preset_selector} <= {s, p};
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic pulse_reset();
		@(posedge clk);
		drive_reset <= 1'b1;
		@(posedge clk);
		drive_reset <= 1'b0;
	endtask
	task automatic test_done();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog; the tests need well under 1000 cycles.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#100000;
		failures++;
		test_done();
	end
	initial begin
		{terminal_autosetup_disable, drive_reset, in_decel, decel_mode_select} = '0;
		{terminal_a, terminal_b, reset} = 3'b111;
		drive_state = SRS_DRV_READY;
		{sequencer_bits, keypad_keys, current_loop_prop_gain, current_loop_int_gain} = 32'h5a3c_1010;
		{speed_abs, bus_voltage, bus_voltage_brake_level} = {16'h0800, 16'h0300, 16'h0200};
		{decel_actual, decel_programmed, preset_scan_interval} = {16'h0000, 16'h0040, 16'h0001};
		{reference_source_select, preset_selector} = {3'h3, 4'h1};
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk("reference after reset", 16'h0000, active_reference);
		chk("preset ind after reset", 16'h0001, 16'(selected_preset_indicator));
		for (int p = 1; p < 9; p++) begin
			sel(3'h3, 4'(p));
			chk("preset reference", 16'h0100 + 16'(p), active_reference);
		end
		for (int p = 2; p < 9; p++) begin
			sel(3'h0, 4'(p));
			chk("analog mode preset", 16'h0100 + 16'(p), active_reference);
		end
		sel(3'h1, 4'h0);
		chk("bits before reset", 16'h0000, 16'(terminals_are_preset_bits));
		pulse_reset();
		for (int t = 0; t < 4; t++) begin
			@(posedge clk);
			{terminal_b, terminal_a} <= 2'(t);
			sel(3'h1, 4'h0);
			chk("terminal preset", (t == 0) ? 16'h0a01 : 16'h0101 + 16'(t), active_reference);
			chk("terminal preset ind", 16'(t + 1), 16'(selected_preset_indicator));
			chk("terminal source ind", 16'h0001, 16'(selected_source_indicator));
		end
		sel(3'h4, 4'h0);
		chk("keypad reference", 16'h0b00, active_reference);
		chk("keypad jog", 16'h0000, 16'(jog_forward_accepted));
		sel(3'h5, 4'h0);
		chk("precision reference", 16'h0c12, active_reference);
		chk("sequencer bits", 16'h005a, 16'(sequencer_command));
		@(posedge clk);
		preset_scan_interval <= 16'h0002;
		sel(3'h3, 4'h9);
		// Each step dwells 2 ms of 2 cycles each, so 4 edges lie between changes.
		for (int i = 0; i < 9; i++) begin
			v     = selected_preset_indicator;
			dwell = 0;
			while (dwell < 20 && selected_preset_indicator === v) begin
				@(posedge clk);
				#1;
				dwell++;
			end
			chk("scan step", 16'(v % 8 + 1), 16'(selected_preset_indicator));
			if (i > 0)
				chk("scan dwell", 16'h0004, 16'(dwell));
		end
		sel(3'h3, 4'h1);
		@(posedge clk);
		in_decel <= 1'b1;
		sel(3'h3, 4'h1);
		chk("fast mode regulator", 16'h0000, 16'(regulator_active));
		chk("decel rate", 16'h0040, decel_rate_limit);
		@(posedge clk);
		in_decel          <= 1'b0;
		decel_mode_select <= 2'h1;
		sel(3'h3, 4'h1);
		@(posedge clk);
		in_decel <= 1'b1;
		sel(3'h3, 4'h1);
		chk("standard regulator", 16'h0001, 16'(regulator_active));
		// Overshoot 0x100 at gain 0x10 adds 0x100 per active edge; four edges give 0x400.
		chk("regulator demand", 16'h0400, current_demand);
		@(posedge clk);
		decel_actual <= 16'h0040;
		sel(3'h3, 4'h1);
		chk("regulator release", 16'h0000, 16'(regulator_active));
		chk("demand after release", 16'h0000, current_demand);
		@(posedge clk);
		in_decel <= 1'b0;
		repeat (60) @(posedge clk);
		#1;
		chk("stall outside decel", 16'h0000, 16'(stall_force_zero));
		// The watchdog fires on the 50th edge without a speed drop, the reference one edge later.
		@(posedge clk);
		in_decel <= 1'b1;
		repeat (49) @(posedge clk);
		#1;
		chk("stall early", 16'h0000, 16'(stall_force_zero));
		@(posedge clk);
		#1;
		chk("stall flag", 16'h0001, 16'(stall_force_zero));
		@(posedge clk);
		#1;
		chk("stall reference", 16'h0000, active_reference);
		@(posedge clk);
		in_decel <= 1'b0;
		sel(3'h0, 4'h2);
		pulse_reset();
		for (int d = 0; d < 4; d++) begin
			@(posedge clk);
			drive_state <= srs_drive_t'(d);
			@(posedge clk);
			#1;
			chk("jog forward", 16'(d != 3), 16'(jog_forward_accepted));
		end
		// Ready state and analog pair terminals: only the keypad source can block jog here.
		@(posedge clk);
		drive_state <= SRS_DRV_READY;
		sel(3'h4, 4'h0);
		chk("keypad jog blocked", 16'h0000, 16'(jog_forward_accepted));
		chk("keypad sequencer", 16'h003c, 16'(sequencer_command));
		test_done();
	end
endmodule
bind srs_speed_ref srs_speed_ref_monitor mon_u (
	.clk                       (clk),
	.reset                     (reset),
	.reference_source_select   (reference_source_select),
	.preset_selector           (preset_selector),
	.preset_values             (preset_values),
	.refs                      (refs),
	.drive_state               (drive_state),
	.in_decel                  (in_decel),
	.decel_mode_select         (decel_mode_select),
	.bus_voltage               (bus_voltage),
	.bus_voltage_brake_level   (bus_voltage_brake_level),
	.decel_actual              (decel_actual),
	.decel_programmed          (decel_programmed),
	.active_reference          (active_reference),
	.selected_source_indicator (selected_source_indicator),
	.jog_forward_accepted      (jog_forward_accepted),
	.stall_force_zero          (stall_force_zero),
	.regulator_active          (regulator_active),
	.decel_rate_limit          (decel_rate_limit)
);
`default_nettype wire
